// ==== hdl/clock_gen_defs.vh ====
// register map, reset values and field positions of the clock generator control bank
// included by the register bank file only; holds only defines
`ifndef CLOCK_GEN_DEFS_VH
`define CLOCK_GEN_DEFS_VH
`define REG_SPARE 3'h0
`define REG_GATE_LO 3'h1
`define REG_GATE_HI 3'h2
`define REG_REVMAKER 3'h3
`define REG_LENGTH 3'h4
`define REG_SWING 3'h5
`define REG_COUNT 6
`define RST_SPARE 8'h00
`define RST_GATE_LO 8'h15
`define RST_GATE_HI 8'he0
`define RST_LENGTH 8'h06
`define RST_SWING 8'hd8
`define BIT_OUT0 4
`define BIT_OUT1 2
`define BIT_OUT2 0
`define BIT_OUT3 7
`define BIT_OUT4 6
`define BIT_OUT5 5
`define BIT_SWING_SEL 7
`define SWING_CODE_HI 6
`define SWING_CODE_LO 4
`define SLAVE_ADDR 7'h6b
`define SWING_BASE_MV 10'd300
`define SWING_STEP_MV 10'd100
`define SWING_DEFAULT_MV 10'd700
`define OUT_DIV_HALF 2'h1
`endif

// ==== hdl/pin_sync.v ====
// three-flop synchroniser with agreement filter for one asynchronous pin
// assumes clock_i is the block clock; reset value chosen by the instance
`timescale 1ns/1ps
module pin_sync #(
    parameter RESET_VAL = 1'b0
) (
    input wire clock_i, // block clock
    input wire resetn_i, // async reset, active low
    input wire pin_i, // raw asynchronous pin
    output reg level_o // filtered level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    // first flop feeds only the second; change counts once second and third agree
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            level_o <= RESET_VAL;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_o <= s3_q;
            end
        end
    end
endmodule

// ==== hdl/output_gate.v ====
// one gated clock output: stops low and restarts only at a cycle boundary
// assumes src_clk_i is a free-running divided clock level in the clock_i domain
`timescale 1ns/1ps
module output_gate (
    input wire clock_i, // block clock
    input wire resetn_i, // async reset, active low
    input wire src_clk_i, // ungated output clock level
    input wire enable_i, // combined pin and register enable
    output reg clk_o, // gated output clock
    output reg running_o // output currently running
);
    // run state only changes while the source is low, so no pulse is cut or stretched
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            running_o <= 1'b0;
            clk_o <= 1'b0;
        end else begin
            if (!src_clk_i) begin
                running_o <= enable_i;
            end
            clk_o <= src_clk_i & (src_clk_i ? running_o : enable_i);
        end
    end
endmodule

// ==== hdl/clock_gen_regs.v ====
// control register bank with smbus byte-read/byte-write slave and six gated outputs
// assumes scl/sda arrive asynchronously and are oversampled by clock_i;
// sda is open-drain: the device pulls low by raising sda_oe_o
`timescale 1ns/1ps
`include "clock_gen_defs.vh"
module clock_gen_regs #(
    parameter [3:0] REVISION_CODE = 4'h1, // arbitrary value
    parameter [3:0] MAKER_CODE = 4'h5 // arbitrary value
) (
    input wire clock_i, // 250 MHz block clock
    input wire resetn_i, // async reset, active low (power-up)
    input wire scl_i, // serial clock pin
    input wire sda_i, // serial data pin level
    output reg sda_o, // serial data drive value, always 0
    output reg sda_oe_o, // high while pulling sda low
    input wire [5:0] gate_pin_i, // per-output gate pins, bit n for output n
    input wire spread_request_pin_i, // spread request pin
    output reg [5:0] clock_out_o, // gated clock outputs
    output reg [5:0] out_running_o, // output n running
    output reg spread_enable_o, // -0.5% spread active
    output reg swing_coded_o, // coded swing in use
    output reg [9:0] swing_mv_o // selected amplitude in mV
);
    localparam ST_IDLE = 6'b000001;
    localparam ST_ADDR = 6'b000010;
    localparam ST_ACK = 6'b000100;
    localparam ST_CMD = 6'b001000;
    localparam ST_WDATA = 6'b010000;
    localparam ST_RDATA = 6'b100000;

    // byte storage, reserved bits kept as written
    reg [7:0] spare_control_byte_q;
    reg [7:0] output_gate_low_group_q;
    reg [7:0] output_gate_high_group_q;
    reg [7:0] revision_and_maker_code_q;
    reg [7:0] transfer_length_q;
    reg [7:0] output_swing_control_q;

    wire scl_s;
    wire sda_s;
    wire spread_s;
    wire [5:0] gate_s;
    reg scl_prev_q;
    reg sda_prev_q;
    reg [5:0] state_q;
    reg [5:0] after_ack_q; // state to enter after the ack slot
    reg [3:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg [2:0] index_q;
    reg is_read_q;
    reg cmd_seen_q;
    reg ack_drive_q;
    reg [1:0] div_q;
    reg src_clk_q;
    wire [5:0] gate_reg;
    wire [5:0] run_w;
    wire [5:0] clk_w;
    wire scl_rise = scl_s & ~scl_prev_q;
    wire scl_fall = ~scl_s & scl_prev_q;
    wire start_cond = scl_s & sda_prev_q & ~sda_s;
    wire stop_cond = scl_s & ~sda_prev_q & sda_s;

    // read mux over the byte index
    function [7:0] read_byte;
        input [2:0] idx;
        begin
            case (idx)
                `REG_SPARE: read_byte = spare_control_byte_q;
                `REG_GATE_LO: read_byte = output_gate_low_group_q;
                `REG_GATE_HI: read_byte = output_gate_high_group_q;
                `REG_REVMAKER: read_byte = revision_and_maker_code_q;
                `REG_LENGTH: read_byte = transfer_length_q;
                `REG_SWING: read_byte = output_swing_control_q;
                default: read_byte = 8'h00;
            endcase
        end
    endfunction

    // swing code to millivolts, linear steps
    function [9:0] code_to_mv;
        input [2:0] code;
        begin
            code_to_mv = `SWING_BASE_MV + `SWING_STEP_MV * {7'h00, code};
        end
    endfunction

    // pins are asynchronous; gate pins idle high, spread pin idles low
    // scl idles high, so its filter resets high: no false rising edge after reset
    pin_sync #(.RESET_VAL(1'b1)) u_scl (.clock_i(clock_i), .resetn_i(resetn_i),
        .pin_i(scl_i), .level_o(scl_s));
    pin_sync #(.RESET_VAL(1'b1)) u_sda (.clock_i(clock_i), .resetn_i(resetn_i),
        .pin_i(sda_i), .level_o(sda_s));
    pin_sync #(.RESET_VAL(1'b0)) u_spread (.clock_i(clock_i), .resetn_i(resetn_i),
        .pin_i(spread_request_pin_i), .level_o(spread_s));

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : gate_lane
            pin_sync #(.RESET_VAL(1'b1)) u_gate (.clock_i(clock_i), .resetn_i(resetn_i),
                .pin_i(gate_pin_i[g]), .level_o(gate_s[g]));
            output_gate u_out (.clock_i(clock_i), .resetn_i(resetn_i),
                .src_clk_i(src_clk_q), .enable_i(gate_s[g] & gate_reg[g]),
                .clk_o(clk_w[g]), .running_o(run_w[g]));
        end
    endgenerate

    assign gate_reg = {output_gate_high_group_q[`BIT_OUT5],
                       output_gate_high_group_q[`BIT_OUT4],
                       output_gate_high_group_q[`BIT_OUT3],
                       output_gate_low_group_q[`BIT_OUT2],
                       output_gate_low_group_q[`BIT_OUT1],
                       output_gate_low_group_q[`BIT_OUT0]};

    // free-running source clock: clock_i divided by 2*(OUT_DIV_HALF+1)
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= 2'h0;
            src_clk_q <= 1'b0;
        end else if (div_q == `OUT_DIV_HALF) begin
            div_q <= 2'h0;
            src_clk_q <= ~src_clk_q;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    // serial slave: byte write and byte read with repeated start
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            spare_control_byte_q <= `RST_SPARE;
            output_gate_low_group_q <= `RST_GATE_LO;
            output_gate_high_group_q <= `RST_GATE_HI;
            revision_and_maker_code_q <= 8'h00;
            transfer_length_q <= `RST_LENGTH;
            output_swing_control_q <= `RST_SWING;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            state_q <= ST_IDLE;
            after_ack_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            index_q <= 3'h0;
            is_read_q <= 1'b0;
            cmd_seen_q <= 1'b0;
            ack_drive_q <= 1'b0;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
            // identity nibbles are fixed by the build, not by writes
            revision_and_maker_code_q <= {REVISION_CODE, MAKER_CODE};
            if (stop_cond) begin
                state_q <= ST_IDLE;
                ack_drive_q <= 1'b0;
                cmd_seen_q <= 1'b0;
            end else if (start_cond) begin
                state_q <= ST_ADDR; // repeated start keeps the indexed byte
                bit_cnt_q <= 4'h0;
                ack_drive_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        ack_drive_q <= 1'b0;
                    end
                    ST_ADDR, ST_CMD, ST_WDATA: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == 4'h8) begin
                            bit_cnt_q <= 4'h0;
                            if (state_q == ST_ADDR) begin
                                if (shift_q[7:1] == `SLAVE_ADDR) begin
                                    ack_drive_q <= 1'b1;
                                    is_read_q <= shift_q[0];
                                    state_q <= ST_ACK;
                                    after_ack_q <= shift_q[0] ? ST_RDATA : ST_CMD;
                                    if (shift_q[0]) begin
                                        shift_q <= read_byte(index_q);
                                    end
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end else if (state_q == ST_CMD) begin
                                index_q <= shift_q[2:0];
                                cmd_seen_q <= 1'b1;
                                ack_drive_q <= 1'b1;
                                state_q <= ST_ACK;
                                after_ack_q <= ST_WDATA;
                            end else begin
                                // every bit stored as written, reserved ones too
                                case (index_q)
                                    `REG_SPARE: spare_control_byte_q <= shift_q;
                                    `REG_GATE_LO: output_gate_low_group_q <= shift_q;
                                    `REG_GATE_HI: output_gate_high_group_q <= shift_q;
                                    `REG_LENGTH: transfer_length_q <= shift_q;
                                    `REG_SWING: output_swing_control_q <= shift_q;
                                    default: ;
                                endcase
                                ack_drive_q <= 1'b1;
                                state_q <= ST_ACK;
                                after_ack_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            ack_drive_q <= 1'b0;
                            state_q <= after_ack_q;
                            if (after_ack_q == ST_RDATA) begin
                                ack_drive_q <= ~shift_q[7];
                            end
                        end
                    end
                    ST_RDATA: begin
                        // one byte then host nacks and stops
                        if (scl_fall) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            shift_q <= {shift_q[6:0], 1'b0};
                            if (bit_cnt_q == 4'h7) begin
                                ack_drive_q <= 1'b0;
                                state_q <= ST_IDLE;
                            end else begin
                                ack_drive_q <= ~shift_q[6];
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // outputs registered; swing selection follows the stored byte, spread follows the spread pin
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            clock_out_o <= 6'h00;
            out_running_o <= 6'h00;
            spread_enable_o <= 1'b0;
            swing_coded_o <= 1'b0;
            swing_mv_o <= `SWING_DEFAULT_MV;
        end else begin
            sda_o <= 1'b0;
            sda_oe_o <= ack_drive_q;
            clock_out_o <= clk_w;
            out_running_o <= run_w;
            spread_enable_o <= spread_s;
            swing_coded_o <= output_swing_control_q[`BIT_SWING_SEL];
            swing_mv_o <= output_swing_control_q[`BIT_SWING_SEL] ?
                code_to_mv(output_swing_control_q[`SWING_CODE_HI:`SWING_CODE_LO]) :
                `SWING_DEFAULT_MV;
        end
    end
endmodule

// ==== verif/clock_gen_regs_checker.sv ====
// checker for the clock generator control bank outputs
// assumes binding onto clock_gen_regs and sees its ports only
`timescale 1ns/1ps
module clock_gen_regs_checker (
    input wire clock_i, // block clock
    input wire resetn_i, // reset, active low
    input wire scl_i, // serial clock
    input wire sda_o, // sda drive value
    input wire sda_oe_o, // sda pull enable
    input wire [5:0] gate_pin_i, // gate pins
    input wire spread_request_pin_i, // spread pin
    input wire [5:0] clock_out_o, // gated clocks
    input wire [5:0] out_running_o, // running flags
    input wire spread_enable_o, // spread state
    input wire swing_coded_o, // coded swing
    input wire [9:0] swing_mv_o // swing in mV
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // a started output 0 must show its whole two-cycle high phase, never a runt
    sequence high_phase_s;
        clock_out_o[0] [*2] ##1 !clock_out_o[0];
    endsequence
    sequence pin_high_s;
        spread_request_pin_i [*8];
    endsequence
    chk_pull_only: assert property (sda_oe_o |-> sda_o == 1'b0)
        else $error("sda drive value not low");
    chk_swing_default: assert property (!swing_coded_o |-> swing_mv_o == 10'd700)
        else $error("default swing wrong");
    chk_swing_range: assert property (swing_coded_o |-> swing_mv_o >= 10'd300 &&
        swing_mv_o <= 10'd1000 && swing_mv_o % 10'd100 == 10'd0)
        else $error("coded swing off the grid");
    chk_stop_low: assert property ((clock_out_o & ~out_running_o & ~$past(out_running_o)) == 6'h00)
        else $error("stopped output not low");
    // the pin is seen low at five points over 16 cycles
    chk_pin_stops: assert property ((out_running_o & ~(gate_pin_i | $past(gate_pin_i, 4) |
        $past(gate_pin_i, 8) | $past(gate_pin_i, 12) | $past(gate_pin_i, 16))) == 6'h00)
        else $error("output runs with gate pin low");
    chk_spread_on: assert property (pin_high_s |-> spread_enable_o)
        else $error("spread not enabled");
    chk_spread_off: assert property (!spread_request_pin_i [*8] |-> !spread_enable_o)
        else $error("spread not disabled");
    chk_sda_steady: assert property (scl_i [*8] |-> $stable(sda_oe_o))
        else $error("sda changed while scl high");
    chk_full_high: assert property ($rose(clock_out_o[0]) |-> high_phase_s)
        else $error("short output pulse");
endmodule
bind clock_gen_regs clock_gen_regs_checker chk (.clock_i, .resetn_i, .scl_i, .sda_o, .sda_oe_o,
    .gate_pin_i, .spread_request_pin_i, .clock_out_o, .out_running_o, .spread_enable_o,
    .swing_coded_o, .swing_mv_o);

// ==== verif/smbus_host_model.sv ====
// serial host model: byte write and byte read transfers
// assumes sda has a pull-up on the bench; the model only pulls low
`timescale 1ns/1ps
module smbus_host_model (
    output logic scl_o, // serial clock, idle high
    output logic sda_low_o, // high while pulling sda low
    input wire sda_i // resolved sda level
);
    // quarter bit; each scl phase is 16 block cycles, above the 10 needed
    localparam time Q = 32ns;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // one bit; sda moves only while scl is low
    task automatic bit_slot(input logic b, output logic r);
        #Q sda_low_o = !b;
        #Q scl_o = 1'b1;
        #Q r = sda_i;
        #Q scl_o = 1'b0;
    endtask
    task automatic start_cond();
        #Q sda_low_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_low_o = 1'b1;
        #Q scl_o = 1'b0;
    endtask
    task automatic stop_cond();
        #Q sda_low_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_low_o = 1'b0;
        #Q;
    endtask
    // msb first, then a released ninth bit: ack in, or nack when reading
    task automatic byte_slot(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(d[i], r);
            q[i] = r;
        end
        bit_slot(1'b1, r);
        ack = !r;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] idx, input logic [7:0] d,
            output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        start_cond();
        byte_slot(adr, q, a0);
        byte_slot(idx, q, a1);
        byte_slot(d, q, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] q);
        logic [7:0] x;
        logic a;
        start_cond();
        byte_slot(8'hd6, x, a);
        byte_slot(idx, x, a);
        start_cond();
        byte_slot(8'hd7, x, a);
        byte_slot(8'hff, q, a);
        stop_cond();
    endtask
endmodule

// ==== verif/test_clock_gen_regs.sv ====
// testbench for the clock generator control bank
// assumes the host model on scl/sda and a pulled-up sda line
`timescale 1ns/1ps
module test_clock_gen_regs;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [5:0] gate_pin_i = 6'h3f;
    logic spread_request_pin_i = 1'b0;
    wire scl_i, sda_low, sda_o, sda_oe_o, spread_enable_o, swing_coded_o;
    wire [5:0] clock_out_o, out_running_o;
    wire [9:0] swing_mv_o;
    int miscompares = 0;
    int cmp_count = 0;
    logic ok;
    logic [7:0] q;
    // open-drain sda: high unless a side pulls it low
    wire sda_i = !(sda_low || sda_oe_o);
    always #2 clock_i = ~clock_i;
    // identity codes here are arbitrary
    clock_gen_regs #(.REVISION_CODE(4'h3), .MAKER_CODE(4'ha)) dut (.clock_i, .resetn_i,
        .scl_i, .sda_i, .sda_o, .sda_oe_o, .gate_pin_i, .spread_request_pin_i,
        .clock_out_o, .out_running_o, .spread_enable_o, .swing_coded_o, .swing_mv_o);
    smbus_host_model host (.scl_o(scl_i), .sda_low_o(sda_low), .sda_i(sda_i));
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        host.wr(8'hd6, {5'h00, idx}, d, ok);
        check(10'(ok), 10'h001);
    endtask
    task automatic rd_check(input logic [2:0] idx, input logic [7:0] exp);
        host.rd({5'h00, idx}, q);
        check(10'(q), 10'(exp));
    endtask
    // bounded wait for the flags, then a stability span
    task automatic expect_run(input logic [5:0] exp);
        for (int i = 0; i < 40 && out_running_o !== exp; i++) @(posedge clock_i);
        repeat (16) @(posedge clock_i);
        check(10'(out_running_o), 10'(exp));
    endtask
    task automatic t_defaults();
        logic [7:0] exp [7] = '{8'h00, 8'h15, 8'he0, 8'h3a, 8'h06, 8'hd8, 8'h00};
        for (int i = 0; i < 7; i++) rd_check(3'(i), exp[i]);
        check(10'(swing_coded_o), 10'h001);
        check(swing_mv_o, 10'd800);
        expect_run(6'h3f);
        $display("test defaults done");
    endtask
    task automatic t_regs();
        logic [7:0] b1 [3] = '{8'hea, 8'h10, 8'h15};
        logic [7:0] b2 [3] = '{8'he0, 8'hbf, 8'he0};
        logic [5:0] run [3] = '{6'h38, 6'h29, 6'h3f};
        wr(3'h0, 8'ha5);
        wr(3'h4, 8'h81);
        wr(3'h3, 8'hff);
        rd_check(3'h0, 8'ha5);
        rd_check(3'h4, 8'h81);
        rd_check(3'h3, 8'h3a);
        for (int i = 0; i < 3; i++) begin
            wr(3'h1, b1[i]);
            wr(3'h2, b2[i]);
            rd_check(3'h1, b1[i]);
            rd_check(3'h2, b2[i]);
            expect_run(run[i]);
        end
        $display("test registers done");
    endtask
    task automatic t_pins();
        for (int k = 0; k < 6; k++) begin
            @(posedge clock_i) gate_pin_i <= ~(6'h01 << k);
            expect_run(~(6'h01 << k));
        end
        @(posedge clock_i) gate_pin_i <= 6'h3f;
        expect_run(6'h3f);
        $display("test pins done");
    endtask
    task automatic t_swing();
        for (int c = 0; c < 8; c++) begin
            wr(3'h5, {1'b1, 3'(c), 4'h0});
            check(swing_mv_o, 10'(300 + 100 * c));
        end
        wr(3'h5, 8'h5f);
        check(swing_mv_o, 10'd700);
        rd_check(3'h5, 8'h5f);
        $display("test swing done");
    endtask
    task automatic t_spread_addr();
        @(posedge clock_i) spread_request_pin_i <= 1'b1;
        for (int i = 0; i < 20 && spread_enable_o !== 1'b1; i++) @(posedge clock_i);
        check(10'(spread_enable_o), 10'h001);
        @(posedge clock_i) spread_request_pin_i <= 1'b0;
        for (int i = 0; i < 20 && spread_enable_o !== 1'b0; i++) @(posedge clock_i);
        check(10'(spread_enable_o), 10'h000);
        host.wr(8'hd4, 8'h00, 8'h77, ok);
        check(10'(ok), 10'h000);
        rd_check(3'h0, 8'ha5);
        $display("test spread and address done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (12) @(posedge clock_i);
        t_defaults();
        t_regs();
        t_pins();
        t_swing();
        t_spread_addr();
        give_verdict();
    end
    // tests take about 160 us; nearly twice that means a hang
    initial begin
        #300us;
        miscompares++;
        give_verdict();
    end
endmodule
